// ---- anar_params.svh ----
`ifndef ANAR_PARAMS_SVH
`define ANAR_PARAMS_SVH

// Register byte offsets
`define ANAR_OFS_CTRL          4'h0
`define ANAR_OFS_ADV           4'h4
`define ANAR_OFS_STAT          4'h8
`define ANAR_OFS_PAGE          4'hC

// Field positions in the advertisement register
`define ANAR_BIT_NEXT_PAGE     15
`define ANAR_BIT_REMOTE_FAULT  13
`define ANAR_BIT_100_FULL      8
`define ANAR_BIT_100_HALF      7
`define ANAR_BIT_10_FULL       6
`define ANAR_BIT_10_HALF       5

// Control and status fields
`define ANAR_BIT_RESTART       0
`define ANAR_BIT_LOADED        0

// Masks and reset values
`define ANAR_WRITE_MASK        16'h21E0
`define ANAR_RSVD_MASK         16'h5E00
`define ANAR_ADV_RESET         16'h01E0
`define ANAR_BE_LOW            0
`define ANAR_BE_HIGH           1

`endif

// ---- anar_pkg.sv ----
package anar_pkg;

  typedef logic [15:0] anar_word_type;

  typedef enum logic {
    NEG_IDLE,
    NEG_ADVERTISE
  } anar_neg_state_type;

endpackage

// ---- anar_page_if.sv ----
`timescale 1ns/1ps

interface anar_page_if;
  logic [15:0] adv;
  logic        capture;
  logic [15:0] page;
  logic        loaded;
  logic        start;

  modport regs  (output adv, output capture,
                 input page, input loaded, input start);
  modport latch (input adv, input capture,
                 output page, output loaded, output start);
endinterface

// ---- anar_page_latch.sv ----
`timescale 1ns/1ps
`include "anar_params.svh"

module anar_page_latch
  import anar_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register side
  anar_page_if.latch pg
);

  anar_neg_state_type state;
  anar_neg_state_type next_state;
  anar_word_type      next_page;
  logic               next_loaded;
  logic               next_start;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state  = state;
    next_page   = pg.page;
    next_start  = 1'b0;
    if (pg.capture) begin
      next_page  = pg.adv;
      next_start = 1'b1;
      next_state = NEG_ADVERTISE;
    end
    next_loaded = (next_state == NEG_ADVERTISE);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state     <= NEG_IDLE;
      pg.page   <= 16'h0000;
      pg.loaded <= 1'b0;
      pg.start  <= 1'b0;
    end else begin
      state     <= next_state;
      pg.page   <= next_page;
      pg.loaded <= next_loaded;
      pg.start  <= next_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence capture_seq;
    pg.capture ##0 pg.adv == pg.adv;
  endsequence

  page_snapshot_a: assert property (
    capture_seq |=> (pg.page == $past(pg.adv)) && pg.start && pg.loaded)
    else $error("page not taken from register at start");

  page_hold_a: assert property (
    !pg.capture |=> $stable(pg.page) && !pg.start)
    else $error("page changed without a restart");

endmodule

// ---- anar_advertise_register.sv ----
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "anar_params.svh"

module anar_advertise_register
  import anar_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  // Negotiation side
  output      logic [15:0] base_page,
  output      logic        neg_start
);

  anar_page_if pg ();

  anar_word_type adv;
  anar_word_type next_adv;
  anar_word_type wmask;
  logic [31:0]   next_rdata;
  logic          next_wait;
  logic          restart;
  logic          next_restart;
  logic          req;
  logic          acc;

  assign req = avs_read || avs_write;
  // Transfer completes on the edge that sees waitrequest low
  assign acc = req && !avs_waitrequest;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] read_mux(input logic [3:0] a,
                                           input anar_word_type v,
                                           input anar_word_type p,
                                           input logic l);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      `ANAR_OFS_ADV:  r = {16'h0000, v & ~`ANAR_RSVD_MASK};
      `ANAR_OFS_STAT: r = {31'h0000_0000, l};
      `ANAR_OFS_PAGE: r = {16'h0000, p};
      default:        r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_wait  = !(req && avs_waitrequest);
    next_rdata = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      next_rdata = read_mux(avs_address, adv, pg.page, pg.loaded);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= next_wait;
      avs_readdata    <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // reserved and next-page bits never written
    wmask = {{8{avs_byteenable[`ANAR_BE_HIGH]}},
             {8{avs_byteenable[`ANAR_BE_LOW]}}} & `ANAR_WRITE_MASK;
    next_adv = adv;
    // remote fault and abilities take writes
    if (acc && avs_write && avs_address == `ANAR_OFS_ADV) begin
      next_adv = (adv & ~wmask) | (avs_writedata[15:0] & wmask);
    end
    next_restart = acc && avs_write && avs_address == `ANAR_OFS_CTRL &&
                   avs_byteenable[`ANAR_BE_LOW] &&
                   avs_writedata[`ANAR_BIT_RESTART];
  end

  // Restart starts high so negotiation begins right after reset
  // abilities reset high
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      adv     <= `ANAR_ADV_RESET;
      restart <= 1'b1;
    end else begin
      adv     <= next_adv;
      restart <= next_restart;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pg.adv     = adv;
  assign pg.capture = restart;
  assign base_page  = pg.page;
  assign neg_start  = pg.start;

  anar_page_latch anar_page_latch_i (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pg       (pg.latch)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence adv_read_done;
    avs_read && !avs_waitrequest && avs_address == `ANAR_OFS_ADV;
  endsequence

  sequence adv_write_done;
    avs_write && !avs_waitrequest && avs_address == `ANAR_OFS_ADV;
  endsequence

  sequence fresh_reset;
    $past(!rst_b) && rst_b;
  endsequence

  bus_answer_a: assert property (
    req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");

  next_page_zero_a: assert property (
    adv_read_done |-> !avs_readdata[`ANAR_BIT_NEXT_PAGE] &&
                      !adv[`ANAR_BIT_NEXT_PAGE])
    else $error("next page bit not zero");

  rsvd_read_zero_a: assert property (
    adv_read_done |-> (avs_readdata[15:0] & `ANAR_RSVD_MASK) == 16'h0000)
    else $error("reserved bits read nonzero");

  fault_write_a: assert property (
    adv_write_done ##0 avs_byteenable[`ANAR_BE_HIGH] |=>
      adv[`ANAR_BIT_REMOTE_FAULT] ==
      $past(avs_writedata[`ANAR_BIT_REMOTE_FAULT]))
    else $error("remote fault write lost");

  reset_value_a: assert property (
    fresh_reset |-> adv == `ANAR_ADV_RESET && adv[`ANAR_BIT_100_FULL])
    else $error("advertisement reset value wrong");

  half100_write_a: assert property (
    adv_write_done ##0 avs_byteenable[`ANAR_BE_LOW] |=>
      adv[`ANAR_BIT_100_HALF] == $past(avs_writedata[`ANAR_BIT_100_HALF]))
    else $error("100 half write lost");

  ability_hold_a: assert property (
    !(avs_write && !avs_waitrequest) |=> $stable(adv[`ANAR_BIT_10_FULL]))
    else $error("ability bit changed without write");

  // Master raises its next request one edge after the answer
  half10_readback_a: assert property (
    adv_write_done ##0 avs_byteenable[`ANAR_BE_LOW] ##2
      avs_read && avs_waitrequest && avs_address == `ANAR_OFS_ADV
      ##0 !$changed(adv)
      |=> avs_readdata[`ANAR_BIT_10_HALF] ==
          $past(avs_writedata[`ANAR_BIT_10_HALF], 3))
    else $error("10 half readback wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake and read paths

  sequence ctrl_read_done;
    avs_read && !avs_waitrequest && avs_address == `ANAR_OFS_CTRL;
  endsequence

  sequence stat_read_done;
    avs_read && !avs_waitrequest && avs_address == `ANAR_OFS_STAT;
  endsequence

  sequence page_read_done;
    avs_read && !avs_waitrequest && avs_address == `ANAR_OFS_PAGE;
  endsequence

  wait_reset_a: assert property (
    fresh_reset |-> avs_waitrequest && avs_readdata == 32'h0000_0000)
    else $error("bus outputs not at reset values");

  wait_single_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  wait_idle_a: assert property (
    !req |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  upper_zero_a: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");

  unmapped_read_a: assert property (
    avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00 |->
      avs_readdata == 32'h0000_0000)
    else $error("unmapped address read nonzero");

  ctrl_read_zero_a: assert property (
    ctrl_read_done |-> avs_readdata == 32'h0000_0000)
    else $error("control register read nonzero");

  stat_read_a: assert property (
    stat_read_done |-> avs_readdata[31:1] == 31'h0000_0000 &&
      avs_readdata[`ANAR_BIT_LOADED] == $past(pg.loaded))
    else $error("status register read wrong");

  page_read_a: assert property (
    page_read_done |-> avs_readdata == {16'h0000, $past(base_page)})
    else $error("page register read wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Field writes and reset values

  rsvd_write_a: assert property (
    adv_write_done |=> (adv & ~`ANAR_WRITE_MASK) == 16'h0000)
    else $error("read-only bit took a write");

  other_write_a: assert property (
    avs_write && !avs_waitrequest && avs_address != `ANAR_OFS_ADV |=>
      $stable(adv))
    else $error("advertisement changed by another address");

  fault_hold_a: assert property (
    !(avs_write && !avs_waitrequest) |=>
      $stable(adv[`ANAR_BIT_REMOTE_FAULT]))
    else $error("remote fault changed without write");

  full100_write_a: assert property (
    adv_write_done ##0 avs_byteenable[`ANAR_BE_HIGH] |=>
      adv[`ANAR_BIT_100_FULL] == $past(avs_writedata[`ANAR_BIT_100_FULL]))
    else $error("100 full write lost");

  full10_write_a: assert property (
    adv_write_done ##0 avs_byteenable[`ANAR_BE_LOW] |=>
      adv[`ANAR_BIT_10_FULL] == $past(avs_writedata[`ANAR_BIT_10_FULL]))
    else $error("10 full write lost");

  lane_low_a: assert property (
    adv_write_done ##0 !avs_byteenable[`ANAR_BE_LOW] |=>
      $stable(adv[`ANAR_BIT_100_HALF:`ANAR_BIT_10_HALF]))
    else $error("low byte changed with lane off");

  lane_high_a: assert property (
    adv_write_done ##0 !avs_byteenable[`ANAR_BE_HIGH] |=>
      $stable(adv[`ANAR_BIT_REMOTE_FAULT]) &&
      $stable(adv[`ANAR_BIT_100_FULL]))
    else $error("high byte changed with lane off");

  reset_fields_a: assert property (
    fresh_reset |-> !adv[`ANAR_BIT_REMOTE_FAULT] &&
      adv[`ANAR_BIT_100_HALF] && adv[`ANAR_BIT_10_FULL] &&
      adv[`ANAR_BIT_10_HALF])
    else $error("field reset value wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Negotiation start and page

  sequence restart_write;
    avs_write && !avs_waitrequest && avs_address == `ANAR_OFS_CTRL &&
      avs_byteenable[`ANAR_BE_LOW] && avs_writedata[`ANAR_BIT_RESTART];
  endsequence

  sequence start_pulse;
    neg_start ##1 !neg_start;
  endsequence

  restart_pulse_a: assert property (
    restart_write |-> ##2 start_pulse)
    else $error("no start pulse after restart");

  page_taken_a: assert property (
    restart_write ##1 1'b1 |=> base_page == $past(adv))
    else $error("base page not taken at start");

  start_cause_a: assert property (
    neg_start |-> !$past(rst_b, 2) ||
      $past(avs_write && !avs_waitrequest &&
            avs_address == `ANAR_OFS_CTRL, 2))
    else $error("start pulse without restart");

  page_hold_top_a: assert property (
    !neg_start |=> neg_start || $stable(base_page))
    else $error("base page changed between starts");

  page_next_zero_a: assert property (
    neg_start |-> !base_page[`ANAR_BIT_NEXT_PAGE])
    else $error("next page bit advertised");

endmodule

// ---- anar_link_partner.sv ----
`timescale 1ns/1ps

module anar_link_partner (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Page offered by the device
  input  wire logic [15:0] base_page,
  input  wire logic        neg_start,
  // What the partner took
  output      logic [15:0] got_page,
  output      int          n_pages
);
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      got_page <= 16'h0000;
      n_pages  <= 0;
    end else if (neg_start) begin
      got_page <= base_page;
      n_pages  <= n_pages + 1;
    end
  end
endmodule

// ---- anar_advertise_register_tb.sv ----
`timescale 1ns/1ps

module anar_advertise_register_tb;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, neg_start;
  logic [15:0] base_page, got_page;
  int          n_pages, err_count = 0, n_compared = 0, cycles = 0;
  int          seed = 83, adv = 16'h01E0;
  // Every page the partner should have seen, newest last
  int          page_q[$] = '{16'h01E0};

  always #25 core_clk = ~core_clk;

  anar_advertise_register anar_advertise_register_i (
    .core_clk        (core_clk),
    .rst_b           (rst_b),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .base_page       (base_page),
    .neg_start       (neg_start)
  );
  anar_link_partner anar_link_partner_i (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .base_page (base_page),
    .neg_start (neg_start),
    .got_page  (got_page),
    .n_pages   (n_pages)
  );

  ////////////////////////////////////////
  task automatic cmp(input string w, input logic [31:0] e, s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask

  // Holds the request until waitrequest is seen low
  task automatic bus(input logic we, input logic [3:0] a,
                     input logic [15:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_address    <= a;
    avs_write      <= we;
    avs_read       <= ~we;
    avs_writedata  <= {d, d};
    avs_byteenable <= be;
    // Ends once waitrequest is seen low; if it never drops, only the bench timeout ends it
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d,
                    input logic [3:0] be);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    bus(1'b1, a, d, be);
    if (a == 4'h4)
      adv = (adv & ~m) | (d & m & 16'h21E0);
    if (a == 4'h0 && be[0] && d[0])
      page_q.push_back(adv);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0000, 4'hF);
    cmp("readdata", e, rd);
  endtask

  // Pulse lands two edges after the write edge
  task automatic pchk();
    repeat (3) @(posedge core_clk);
    cmp("page", page_q[$], got_page);
    cmp("base_page", page_q[$], base_page);
    cmp("pulses", page_q.size(), n_pages);
  endtask

  task automatic wrap_up();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    pchk();
    rchk(4'h4, 32'h000001E0);
    wr(4'h4, 16'hFFFF, 4'h3);
    rchk(4'h4, 32'h000021E0);
    wr(4'h4, 16'h0000, 4'h3);
    rchk(4'h4, 32'h0);
    for (int i = 0; i < 24; i++) begin
      wr(4'h4, 16'($random(seed)), 4'($random(seed)));
      rchk(4'h4, adv);
    end
    pchk();
    wr(4'h4, 16'hFFFF, 4'h3);
    // clear 100 full, keep the rest
    bus(1'b0, 4'h4, 16'h0000, 4'hF);
    wr(4'h4, rd[15:0] & 16'hFEFF, 4'h3);
    wr(4'h0, 16'h0001, 4'h1);
    pchk();
    wr(4'h0, 16'h0001, 4'h1);
    wr(4'h0, 16'h0001, 4'h1);
    pchk();
    for (int a = 1; a < 16; a++) begin
      if (a % 4 != 0) begin
        wr(4'(a), 16'hFFFF, 4'h3);
        rchk(4'(a), 32'h0);
      end
    end
    rchk(4'h4, adv);
    rchk(4'h0, 32'h0);
    rchk(4'h8, 32'h1);
    rchk(4'hC, page_q[$]);
    pchk();
    wrap_up();
  end
endmodule
